// File: hw/boc_apb_slave.sv
// plain apb slave: one-cycle access, pslverr on unmapped offsets
module boc_apb_slave (
   // clock and reset
   input  wire logic        clk_in,
   input  wire logic        rst_b_in,
   // apb
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [11:0] paddr_in,
   input  wire logic [31:0] pwdata_in,
   output logic             pready_out,
   output logic             pslverr_out,
   output logic [31:0]      prdata_out,
   // register view
   input  wire logic [31:0] status_in,
   input  wire logic [31:0] ctx_word_in,
   output logic             ctx_save_out,
   output logic             ctx_restore_out,
   output logic             ctx_load_out,
   output logic [31:0]      ctx_data_out
);
   logic        acc;
   logic        mapped;
   logic [31:0] next_prdata;
   logic        next_pslverr;
   logic        next_save;
   logic        next_restore;
   logic        next_load;
   logic [31:0] next_ctx_data;

   assign acc = psel_in && penable_in;

   // decode; control words are internal, only context and status reach software
   always_comb begin
      mapped        = (paddr_in == boc_pkg::REG_CTX) || (paddr_in == boc_pkg::REG_STATUS);
      next_prdata   = 32'h0000_0000;
      next_pslverr  = 1'b0;
      next_save     = 1'b0;
      next_restore  = 1'b0;
      next_load     = 1'b0;
      next_ctx_data = ctx_data_out;
      if (psel_in && !penable_in) begin
         next_pslverr = !mapped;
         if (!pwrite_in && paddr_in == boc_pkg::REG_CTX) begin
            next_prdata = ctx_word_in;
         end else if (!pwrite_in && paddr_in == boc_pkg::REG_STATUS) begin
            next_prdata = status_in;
         end
      end
      if (acc && pwrite_in && paddr_in == boc_pkg::REG_CTX) begin
         next_load     = 1'b1;
         next_ctx_data = pwdata_in;
      end else if (acc && pwrite_in && paddr_in == boc_pkg::REG_STATUS) begin
         next_save    = (pwdata_in == boc_pkg::CTX_SAVE);
         next_restore = (pwdata_in == boc_pkg::CTX_RESTORE);
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         prdata_out      <= 32'h0000_0000;
         pready_out      <= 1'b0;
         pslverr_out     <= 1'b0;
         ctx_save_out    <= 1'b0;
         ctx_restore_out <= 1'b0;
         ctx_load_out    <= 1'b0;
         ctx_data_out    <= 32'h0000_0000;
      end else begin
         pready_out <= 1'b1; // zero wait states
         // read data set up in the setup cycle so it is stable at the access edge
         if (psel_in && !penable_in) begin
            prdata_out  <= next_prdata;
            pslverr_out <= next_pslverr;
         end
         ctx_save_out    <= next_save;
         ctx_restore_out <= next_restore;
         ctx_load_out    <= next_load;
         ctx_data_out    <= next_ctx_data;
      end
   end
endmodule

// File: hw/boc_line_walker.sv
// steps one scan line of monochrome source bits and reports word-aligned skip
module boc_line_walker #(
   parameter int WIDTH_BITS = 8
) (
   // clock and reset
   input  wire logic                  clk_in,
   input  wire logic                  rst_b_in,
   // control
   input  wire logic                  start_in,
   input  wire logic [WIDTH_BITS-1:0] width_in,
   input  wire logic [2:0]            mono_start_in,
   input  wire logic                  byte_packed_in,
   input  wire logic                  mono_src_in,
   // status
   output logic                       line_done_out,
   output logic [15:0]                bit_pos_out
);
   initial begin
      if (WIDTH_BITS < 1 || WIDTH_BITS > 12) $error("width bits out of range");
   end

   logic [WIDTH_BITS-1:0] left;
   logic [WIDTH_BITS-1:0] next_left;
   logic                  active;
   logic                  next_active;
   logic [15:0]           next_pos;
   logic                  next_done;
   logic [15:0]           step;

   // one pixel is a bit, or a whole byte when byte packed
   always_comb begin
      step        = byte_packed_in ? 16'h0008 : 16'h0001;
      next_left   = left;
      next_active = active;
      next_pos    = bit_pos_out;
      next_done   = 1'b0;
      if (start_in) begin
         next_left   = width_in;
         next_active = (width_in != '0);
         next_pos    = mono_src_in ? {13'h0000, mono_start_in} : 16'h0000;
         next_done   = (width_in == '0);
      end else if (active) begin
         next_pos  = bit_pos_out + step;
         next_left = left - 1'b1;
         if (left == {{(WIDTH_BITS-1){1'b0}}, 1'b1}) begin
            next_active = 1'b0;
            next_done   = 1'b1;
            // round up to the next 16-bit word; leftover bits are dropped
            if (mono_src_in) begin
               next_pos = (next_pos + 16'(boc_pkg::WORD_BITS) - 16'h0001) & 16'hFFF0;
            end
         end
      end
   end

   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         left          <= '0;
         active        <= 1'b0;
         bit_pos_out   <= 16'h0000;
         line_done_out <= 1'b0;
      end else begin
         left          <= next_left;
         active        <= next_active;
         bit_pos_out   <= next_pos;
         line_done_out <= next_done;
      end
   end
endmodule

// File: hw/boc_pkg.sv
// Functional notes
// - bit 31 of the control word reads 1 while the engine executes and 0 when idle, resetting idle.
// - the busy bit is copied into the setup-command copy of the word so the two always agree.
// - bit 30 is 1 while the executing command clips and 0 otherwise, resetting to 0; here a context restore while idle loads it from the saved word.
// - bit 29 is decoded from the setup opcode, 0 colour and 1 monochrome pattern, resetting colour.
// - bits 28:22 hold the opcode of the last accepted command, resetting to zero.
// - the engine state machine picks its operation from the stored 7-bit opcode; here the state sequence ignores the opcode.
// - the stored opcode decides whether source and pattern are colour or monochrome.
// - bits 21:20 act only at 32 bpp, upper bit enables alpha writes, lower bit enables RGB writes.
// - bits 19:17 give the first pixel bit in the first byte of each monochrome source line.
// - monochrome source lines are word aligned, skipping bits to the next 16-bit boundary.
// - bit 16 selects bit packed (0) or byte packed (1) monochrome source.
// - the word is internal, not software readable, and is saved and restored with context.
package boc_pkg;
   // register offsets on the APB side
   localparam logic [11:0] REG_CTRL_WORD  = 12'h000;
   localparam logic [11:0] REG_SETUP_WORD = 12'h004;
   localparam logic [11:0] REG_CTX        = 12'h008;
   localparam logic [11:0] REG_STATUS     = 12'h00C;
   // field positions of the control word
   localparam int BUSY_BIT   = 31;
   localparam int CLIP_BIT   = 30;
   localparam int MPAT_BIT   = 29;
   localparam int OPC_HI     = 28;
   localparam int OPC_LO     = 22;
   localparam int MASK_HI    = 21;
   localparam int MASK_LO    = 20;
   localparam int START_HI   = 19;
   localparam int START_LO   = 17;
   localparam int PACK_BIT   = 16;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // opcode bits that classify operands, then the bpp, word size and context command codes
   localparam int OPC_SETUP_BIT   = 6;
   localparam int OPC_MONO_SRC    = 5;
   localparam int OPC_MONO_PAT    = 4;
   localparam logic [1:0] BPP_32  = 2'h3;
   localparam logic [4:0] WORD_BITS = 5'h10;
   localparam logic [31:0] CTX_SAVE    = 32'h0000_0001;
   localparam logic [31:0] CTX_RESTORE = 32'h0000_0002;

   typedef struct packed {
      logic       busy;
      logic       clip;
      logic       mono_pat;
      logic [6:0] opcode;
      logic [1:0] byte_mask;
      logic [2:0] mono_start;
      logic       byte_packed;
      logic [15:0] rsvd;
   } boc_word_t;

   typedef struct packed {
      logic       valid;
      logic [6:0] opcode;
      logic       clip;
      logic [1:0] byte_mask;
      logic [2:0] mono_start;
      logic       byte_packed;
      logic [1:0] bpp;
      logic [7:0] width;
      logic [7:0] height;
   } boc_cmd_t;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_RUN  = 2'h1,
      ST_LINE = 2'h3,
      ST_DONE = 2'h2
   } boc_state_t;
endpackage

// File: hw/boc_top.sv
// opcode and control state of the block-transfer engine
//
// Design decisions made here: the address map and the APB slave port.
module boc_top #(
   parameter int WIDTH_BITS = 8
) (
   // clock and reset
   input  wire logic           core_clk_in,
   input  wire logic           rst_b_in,
   // apb
   input  wire logic           psel_in,
   input  wire logic           penable_in,
   input  wire logic           pwrite_in,
   input  wire logic [11:0]    paddr_in,
   input  wire logic [31:0]    pwdata_in,
   output logic                pready_out,
   output logic                pslverr_out,
   output logic [31:0]         prdata_out,
   // command from the parser
   input  wire boc_pkg::boc_cmd_t cmd_in,
   output logic                cmd_ready_out,
   // destination write handshake
   input  wire logic           dst_wr_ack_in,
   output logic                dst_wr_out,
   output logic [3:0]          dst_be_out,
   // engine view of the word
   output logic [31:0]         ctrl_word_out,
   output logic [31:0]         setup_word_out,
   output logic                mono_src_out,
   output logic                mono_pat_out,
   output logic [15:0]         src_bit_pos_out
);
   initial begin
      if (WIDTH_BITS != 8) $error("command width field is fixed at 8 bits");
   end

   // reset release through two flops
   logic rst_s1;
   logic rst_sync;
   always_ff @(posedge core_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rst_s1   <= 1'b0;
         rst_sync <= 1'b0;
      end else begin
         rst_s1   <= 1'b1;
         rst_sync <= rst_s1;
      end
   end

   boc_pkg::boc_word_t word;
   boc_pkg::boc_word_t next_word;
   boc_pkg::boc_word_t setup_word;
   boc_pkg::boc_word_t next_setup_word;
   boc_pkg::boc_word_t saved;
   boc_pkg::boc_word_t next_saved;
   boc_pkg::boc_state_t state;
   boc_pkg::boc_state_t next_state;
   logic [7:0]  lines_left;
   logic [7:0]  next_lines_left;
   logic [7:0]  width_q;
   logic [7:0]  next_width_q;
   logic [1:0]  bpp;
   logic [1:0]  next_bpp;
   logic        next_cmd_ready;
   logic        next_dst_wr;
   logic [3:0]  next_be;
   logic        line_start;
   logic        line_done;
   logic [15:0] bit_pos;
   logic        ctx_save;
   logic        ctx_restore;
   logic        ctx_load;
   logic [31:0] ctx_data;
   logic [31:0] status;

   assign status = {30'h0000_0000, state};

   boc_apb_slave u_apb (
      .clk_in          (core_clk_in),
      .rst_b_in        (rst_sync),
      .psel_in         (psel_in),
      .penable_in      (penable_in),
      .pwrite_in       (pwrite_in),
      .paddr_in        (paddr_in),
      .pwdata_in       (pwdata_in),
      .pready_out      (pready_out),
      .pslverr_out     (pslverr_out),
      .prdata_out      (prdata_out),
      .status_in       (status),
      .ctx_word_in     (saved),
      .ctx_save_out    (ctx_save),
      .ctx_restore_out (ctx_restore),
      .ctx_load_out    (ctx_load),
      .ctx_data_out    (ctx_data)
   );

   boc_line_walker #(.WIDTH_BITS(WIDTH_BITS)) u_walk (
      .clk_in         (core_clk_in),
      .rst_b_in       (rst_sync),
      .start_in       (line_start),
      .width_in       (width_q),
      .mono_start_in  (word.mono_start),
      .byte_packed_in (word.byte_packed),
      .mono_src_in    (word.opcode[boc_pkg::OPC_MONO_SRC]),
      .line_done_out  (line_done),
      .bit_pos_out    (bit_pos)
   );

   logic line_done_pending;
   logic next_line_done_pending;
   logic line_walking;
   logic next_line_walking;

   // one start per line; start drops while the walker runs, so it never reloads mid-line
   assign line_start = (state == boc_pkg::ST_LINE) && !dst_wr_out && !line_done_pending &&
                       !line_walking;

   // engine sequencing: accept, walk lines, final write, drop busy
   always_comb begin
      next_state      = state;
      next_word       = word;
      next_setup_word = setup_word;
      next_saved      = saved;
      next_lines_left = lines_left;
      next_width_q    = width_q;
      next_bpp        = bpp;
      next_cmd_ready  = 1'b0;
      next_dst_wr     = dst_wr_out;
      next_be         = dst_be_out;
      next_line_done_pending = line_done_pending;
      next_line_walking      = line_start || (line_walking && !line_done);
      unique case (state)
         boc_pkg::ST_IDLE: begin
            next_cmd_ready = 1'b1;
            if (cmd_in.valid && cmd_ready_out) begin
               next_cmd_ready        = 1'b0;
               next_word.busy        = 1'b1;
               next_word.clip        = cmd_in.clip;
               next_word.opcode      = cmd_in.opcode;
               next_word.byte_mask   = cmd_in.byte_mask;
               next_word.mono_start  = cmd_in.mono_start;
               next_word.byte_packed = cmd_in.byte_packed;
               next_bpp              = cmd_in.bpp;
               next_width_q          = cmd_in.width;
               next_lines_left       = cmd_in.height;
               // a setup command fixes pattern kind for later scan-line copies
               if (cmd_in.opcode[boc_pkg::OPC_SETUP_BIT]) begin
                  next_word.mono_pat = cmd_in.opcode[boc_pkg::OPC_MONO_PAT];
               end
               // zero-height commands do no access and finish at once
               next_state = (cmd_in.height == 8'h00) ? boc_pkg::ST_DONE
                                                     : boc_pkg::ST_RUN;
            end
         end
         boc_pkg::ST_LINE: begin
            if (line_done) begin
               next_line_done_pending = 1'b1;
            end
            if (line_done || line_done_pending) begin
               if (!dst_wr_out) begin
                  next_dst_wr = 1'b1;
                  // channel mask only means something at 32 bpp
                  next_be = (bpp == boc_pkg::BPP_32) ?
                            {word.byte_mask[1], {3{word.byte_mask[0]}}} : 4'hF;
               end else if (dst_wr_ack_in) begin
                  next_dst_wr            = 1'b0;
                  next_line_done_pending = 1'b0;
                  next_lines_left        = lines_left - 8'h01;
                  if (lines_left == 8'h01) begin
                     next_state = boc_pkg::ST_DONE;
                  end
               end
            end
         end
         boc_pkg::ST_DONE: begin
            next_word.busy = 1'b0;
            next_word.clip = 1'b0;
            next_state     = boc_pkg::ST_IDLE;
         end
         boc_pkg::ST_RUN: begin
            next_state = boc_pkg::ST_LINE;
         end
      endcase
      // context switch: save or load the snapshot at any time, restore it only while idle
      if (ctx_save) begin
         next_saved = word;
      end
      if (ctx_load) begin
         next_saved = boc_pkg::boc_word_t'(ctx_data);
      end
      if (ctx_restore && state == boc_pkg::ST_IDLE) begin
         next_word      = saved;
         next_word.busy = 1'b0;
      end
      next_word.rsvd = 16'h0000;
      // setup copy tracks busy every cycle
      next_setup_word.busy = next_word.busy;
      if (state == boc_pkg::ST_IDLE && cmd_in.valid && cmd_ready_out &&
          cmd_in.opcode[boc_pkg::OPC_SETUP_BIT]) begin
         next_setup_word      = next_word;
      end
   end

   always_ff @(posedge core_clk_in or negedge rst_sync) begin
      if (!rst_sync) begin
         state             <= boc_pkg::ST_IDLE;
         word              <= boc_pkg::boc_word_t'(boc_pkg::CTRL_RESET);
         setup_word        <= boc_pkg::boc_word_t'(boc_pkg::CTRL_RESET);
         saved             <= boc_pkg::boc_word_t'(boc_pkg::CTRL_RESET);
         lines_left        <= 8'h00;
         width_q           <= 8'h00;
         bpp               <= 2'h0;
         cmd_ready_out     <= 1'b0;
         dst_wr_out        <= 1'b0;
         dst_be_out        <= 4'h0;
         line_done_pending <= 1'b0;
         line_walking      <= 1'b0;
      end else begin
         state             <= next_state;
         word              <= next_word;
         setup_word        <= next_setup_word;
         saved             <= next_saved;
         lines_left        <= next_lines_left;
         width_q           <= next_width_q;
         bpp               <= next_bpp;
         cmd_ready_out     <= next_cmd_ready;
         dst_wr_out        <= next_dst_wr;
         dst_be_out        <= next_be;
         line_done_pending <= next_line_done_pending;
         line_walking      <= next_line_walking;
      end
   end

   // registered engine view
   always_ff @(posedge core_clk_in or negedge rst_sync) begin
      if (!rst_sync) begin
         ctrl_word_out   <= boc_pkg::CTRL_RESET;
         setup_word_out  <= boc_pkg::CTRL_RESET;
         mono_src_out    <= 1'b0;
         mono_pat_out    <= 1'b0;
         src_bit_pos_out <= 16'h0000;
      end else begin
         ctrl_word_out   <= next_word;
         setup_word_out  <= next_setup_word;
         mono_src_out    <= next_word.opcode[boc_pkg::OPC_MONO_SRC];
         mono_pat_out    <= next_word.opcode[boc_pkg::OPC_SETUP_BIT] ?
                            next_word.mono_pat
                            : next_word.opcode[boc_pkg::OPC_MONO_PAT];
         src_bit_pos_out <= bit_pos;
      end
   end
endmodule

// File: tb/boc_monitor.sv
// port-level checks of the control word, attached by bind
module boc_monitor #(
   parameter int WIDTH_BITS = 8
) (
   // clock and reset
   input wire logic              core_clk_in,
   input wire logic              rst_b_in,
   // parser side and destination handshake
   input wire boc_pkg::boc_cmd_t cmd_in,
   input wire logic              cmd_ready_out,
   input wire logic              dst_wr_ack_in,
   input wire logic              dst_wr_out,
   // engine view of the word
   input wire logic [31:0]       ctrl_word_out,
   input wire logic [31:0]       setup_word_out,
   input wire logic              mono_src_out,
   input wire logic              mono_pat_out,
   input wire logic [15:0]       src_bit_pos_out
);
   timeunit 1ns / 100ps;
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!rst_b_in);

   // a command offered and taken in one edge
   sequence accept_s;
      cmd_in.valid && cmd_ready_out;
   endsequence
   // a destination write not yet acknowledged
   sequence wr_wait_s;
      dst_wr_out && !dst_wr_ack_in;
   endsequence

   busy_mirror_a: assert property (setup_word_out[31] == ctrl_word_out[31])
      else $error("busy copy differs");
   busy_rise_a: assert property (accept_s |=> ctrl_word_out[31])
      else $error("busy missing after accept");
   opcode_cap_a: assert property (accept_s |=> ctrl_word_out[28:22] == $past(cmd_in.opcode))
      else $error("opcode not captured");
   clip_cap_a: assert property (accept_s |=> ctrl_word_out[30] == $past(cmd_in.clip))
      else $error("clip not captured");
   field_cap_a: assert property (accept_s |=> ctrl_word_out[21:16] ==
      $past({cmd_in.byte_mask, cmd_in.mono_start, cmd_in.byte_packed}))
      else $error("mask start or pack not captured");
   busy_refuse_a: assert property (ctrl_word_out[31] |-> !cmd_ready_out)
      else $error("ready while busy");
   busy_hold_a: assert property (wr_wait_s |=> ctrl_word_out[31])
      else $error("busy fell before final write");
   opcode_keep_a: assert property (ctrl_word_out[31] && $past(ctrl_word_out[31])
      |-> $stable(ctrl_word_out[28:16]))
      else $error("fields moved mid command");
   src_kind_a: assert property (ctrl_word_out[31] |-> mono_src_out == ctrl_word_out[27])
      else $error("source kind not from opcode");
   pat_kind_a: assert property (ctrl_word_out[31] |->
      mono_pat_out == (ctrl_word_out[28] ? ctrl_word_out[29] : ctrl_word_out[26]))
      else $error("pattern kind differs");
   word_align_a: assert property ($rose(dst_wr_out) && mono_src_out && !ctrl_word_out[16]
      |-> src_bit_pos_out[3:0] == 4'h0)
      else $error("line end not word aligned");
endmodule

bind boc_top boc_monitor #(.WIDTH_BITS(WIDTH_BITS)) i_boc_monitor (
   .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .cmd_in(cmd_in),
   .cmd_ready_out(cmd_ready_out), .dst_wr_ack_in(dst_wr_ack_in), .dst_wr_out(dst_wr_out),
   .ctrl_word_out(ctrl_word_out), .setup_word_out(setup_word_out),
   .mono_src_out(mono_src_out), .mono_pat_out(mono_pat_out),
   .src_bit_pos_out(src_bit_pos_out));

// File: tb/boc_parser_model.sv
// command parser and destination acknowledger in front of the engine
module boc_parser_model (
   // clock and reset
   input  wire logic              clk_in,
   input  wire logic              rst_b_in,
   // bench request
   input  wire logic              send_in,
   input  wire boc_pkg::boc_cmd_t cmd_req_in,
   input  wire logic [3:0]        ack_lat_in,
   // engine side
   input  wire logic              cmd_ready_in,
   input  wire logic              dst_wr_in,
   output boc_pkg::boc_cmd_t      cmd_out,
   output logic                   dst_wr_ack_out
);
   timeunit 1ns / 100ps;
   logic [3:0] wait_cnt;

   // offer held until taken; stale fields scrambled so nothing leans on them
   always_ff @(posedge clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cmd_out        <= '0;
         dst_wr_ack_out <= 1'b0;
         wait_cnt       <= 4'h0;
      end else begin
         if (send_in) begin
            cmd_out <= cmd_req_in;
         end else if (cmd_out.valid && cmd_ready_in) begin
            cmd_out       <= ~cmd_out;
            cmd_out.valid <= 1'b0;
         end
         // one-cycle ack after a chosen stall
         dst_wr_ack_out <= 1'b0;
         if (dst_wr_in && !dst_wr_ack_out) begin
            if (wait_cnt >= ack_lat_in) begin
               dst_wr_ack_out <= 1'b1;
               wait_cnt       <= 4'h0;
            end else begin
               wait_cnt <= wait_cnt + 4'h1;
            end
         end
      end
   end
endmodule

// File: tb/tb_boc_top.sv
module tb_boc_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic              core_clk_in = 1'b0;
   logic              rst_b_in = 1'b0;
   logic              psel_in = 1'b0;
   logic              penable_in = 1'b0;
   logic              pwrite_in = 1'b0;
   logic [11:0]       paddr_in = 12'h000;
   logic [31:0]       pwdata_in = 32'h0;
   logic              send = 1'b0;
   boc_pkg::boc_cmd_t req = '0;
   logic [3:0]        lat = 4'h0;
   boc_pkg::boc_cmd_t cmd_in;
   logic              pready_out, pslverr_out, cmd_ready_out, dst_wr_ack_in, dst_wr_out;
   logic              mono_src_out, mono_pat_out;
   logic [31:0]       prdata_out, ctrl_word_out, setup_word_out, last_word, q;
   logic [3:0]        dst_be_out;
   logic [15:0]       src_bit_pos_out;
   logic              e;
   int                err_count = 0;
   int                samples_checked = 0;

   always #10 core_clk_in = ~core_clk_in;

   boc_top #(.WIDTH_BITS(8)) i_boc_top (
      .core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .psel_in(psel_in),
      .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
      .pwdata_in(pwdata_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .prdata_out(prdata_out), .cmd_in(cmd_in), .cmd_ready_out(cmd_ready_out),
      .dst_wr_ack_in(dst_wr_ack_in), .dst_wr_out(dst_wr_out), .dst_be_out(dst_be_out),
      .ctrl_word_out(ctrl_word_out), .setup_word_out(setup_word_out),
      .mono_src_out(mono_src_out), .mono_pat_out(mono_pat_out),
      .src_bit_pos_out(src_bit_pos_out));

   boc_parser_model i_boc_parser_model (
      .clk_in(core_clk_in), .rst_b_in(rst_b_in), .send_in(send), .cmd_req_in(req),
      .ack_lat_in(lat), .cmd_ready_in(cmd_ready_out), .dst_wr_in(dst_wr_out),
      .cmd_out(cmd_in), .dst_wr_ack_out(dst_wr_ack_in));

   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task print_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, err_count);
      if (err_count == 0 && samples_checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask

   // one apb transfer; read data and error taken at the pready edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge core_clk_in);
      psel_in    <= 1'b1;
      penable_in <= 1'b0;
      pwrite_in  <= w;
      paddr_in   <= a;
      pwdata_in  <= d;
      @(posedge core_clk_in);
      penable_in <= 1'b1;
      n = 0;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (pready_out !== 1'b1 && n < 50);
      if (pready_out !== 1'b1) err_count++;
      q = prdata_out;
      e = pslverr_out;
      psel_in    <= 1'b0;
      penable_in <= 1'b0;
   endtask

   // one command through the parser model, checked against the word model
   task run_cmd(input boc_pkg::boc_cmd_t c);
      logic [31:0] exp, msk;
      logic [3:0]  be;
      logic [15:0] sp;
      int          n, k;
      @(posedge core_clk_in);
      send <= 1'b1;
      req  <= c;
      @(posedge core_clk_in);
      send <= 1'b0;
      k = 0;
      while (!(cmd_in.valid && cmd_ready_out) && k < 100) begin
         @(posedge core_clk_in);
         k++;
      end
      exp = {1'b1, c.clip, c.opcode[4], c.opcode, c.byte_mask, c.mono_start, c.byte_packed,
             16'h0000};
      msk = c.opcode[6] ? 32'hFFFFFFFF : 32'hDFFFFFFF; // pattern kind only from setup
      be = (c.bpp == boc_pkg::BPP_32) ? {c.byte_mask[1], {3{c.byte_mask[0]}}} : 4'hF;
      sp = 16'((32'(c.mono_start) + 32'(c.width) * (c.byte_packed ? 32'h8 : 32'h1) + 32'hF) &
               32'hFFF0);
      @(posedge core_clk_in);
      check(ctrl_word_out & msk, exp & msk);
      check(32'(setup_word_out[31]), 32'h1);
      check(32'(mono_src_out), 32'(c.opcode[5]));
      check(32'(mono_pat_out), 32'(c.opcode[4]));
      n = 0;
      k = 0;
      while (n < c.height && k < 5000) begin
         check(32'(ctrl_word_out[31]), 32'h1);
         if (dst_wr_out === 1'b1) begin
            check(32'(dst_be_out), 32'(be));
            if (c.opcode[5]) check(32'(src_bit_pos_out), 32'(sp));
            if (dst_wr_ack_in === 1'b1) n++;
         end
         if (n < c.height) @(posedge core_clk_in);
         k++;
      end
      k = 0;
      while (ctrl_word_out[31] !== 1'b0 && k < 3) begin
         @(posedge core_clk_in);
         k++;
      end
      check(32'(ctrl_word_out[31]), 32'h0);
      check(32'(ctrl_word_out[28:22]), 32'(c.opcode));
      last_word = exp;
      $display("command test done");
   endtask

   initial begin
      boc_pkg::boc_cmd_t c;
      logic [31:0]       v;
      void'($urandom(91));
      repeat (5) @(posedge core_clk_in);
      rst_b_in <= 1'b1;
      repeat (3) @(posedge core_clk_in);
      check(ctrl_word_out, boc_pkg::CTRL_RESET);
      check(setup_word_out, 32'h00000000);
      $display("reset test done");
      // every mask, setup or not, each pattern kind, random source kind, both packings
      for (int i = 0; i < 16; i++) begin
         c             = '0;
         c.valid       = 1'b1;
         c.opcode      = (i == 15) ? 7'h7F : 7'($urandom);
         c.opcode[6]   = (i == 15) | i[2];
         c.opcode[4]   = (i == 15) | i[3];
         c.clip        = i[0];
         c.byte_mask   = i[1:0];
         c.mono_start  = (i == 7) ? 3'h7 : 3'($urandom);
         c.byte_packed = i[1] ^ i[3];
         c.bpp         = (i < 8) ? boc_pkg::BPP_32 : 2'($urandom_range(2, 0));
         c.width       = 8'($urandom_range(15, 1));
         c.height      = 8'($urandom_range(3, 1));
         lat <= 4'($urandom);
         run_cmd(c);
      end
      // word is not software visible; context save and restore are
      apb(1'b0, boc_pkg::REG_CTRL_WORD, 32'h0);
      check(32'(e), 32'h1);
      apb(1'b0, boc_pkg::REG_SETUP_WORD, 32'h0);
      check(32'(e), 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      check(32'(e), 32'h1);
      apb(1'b1, boc_pkg::REG_STATUS, boc_pkg::CTX_SAVE);
      check(32'(e), 32'h0);
      apb(1'b0, boc_pkg::REG_CTX, 32'h0);
      check(32'(q[28:16]), 32'(last_word[28:16]));
      v = $urandom & 32'h7FFF0000;
      apb(1'b1, boc_pkg::REG_CTX, v);
      apb(1'b1, boc_pkg::REG_STATUS, boc_pkg::CTX_RESTORE);
      repeat (3) @(posedge core_clk_in);
      check(ctrl_word_out, v);
      check(32'(setup_word_out[31]), 32'h0);
      $display("context test done");
      print_verdict;
   end

   // hang guard
   initial begin
      repeat (60000) @(posedge core_clk_in);
      err_count++;
      print_verdict;
   end
endmodule
